// File: pacdac_regs.svh
// Register offsets, fields, reset values and timing counts of the DAC update and monitor block.
// Behaviour
// (R01) Current result offset binary, mid is zero
// (R02) Current gain selectable, LSB scales inversely
// (R03) Three temperatures refreshed every 5 ms
// (R04) Local temperature code is eighth degree steps
// (R05) Sequencer converts selected internal channels in order
// (R06) Internal channel conversions always single ended
// (R07) Negative supply code zero is minus 7.5
// (R08) Bipolar monitor code zero is minus five
// (R09) Eight 12-bit DAC codes, four bipolar
// (R10) Bipolar range select offsets three ranges
// (R11) Unipolar range select offsets three ranges
// (R12) Load bit defers code until strobe
// (R13) Bipolar copy bit broadcasts in open loop
// (R14) Unipolar copy bit broadcasts to all unipolar
// (R15) Separate input and output code stages
// (R16) Output equals scaled code plus range offset
// (R17) Clamp leaves stored output codes unchanged
// (R18) Pending codes transfer together on strobe
// (R19) Closed loop copy updates addressed channel only
`ifndef PACDAC_REGS_SVH
`define PACDAC_REGS_SVH
`define PACDAC_ADDR_W       6
`define PACDAC_DAC_IN_BASE  6'h00
`define PACDAC_DAC_OUT_BASE 6'h08
`define PACDAC_RANGE_BI     6'h10
`define PACDAC_RANGE_UNI    6'h11
`define PACDAC_CTRL         6'h12
`define PACDAC_GAIN         6'h13
`define PACDAC_SEQ_EN       6'h14
`define PACDAC_STATUS       6'h15
`define PACDAC_ADC_IN       6'h16
`define PACDAC_RES_BASE     6'h20
`define PACDAC_CODE_LOAD    12
`define PACDAC_CODE_COPY    13
`define PACDAC_CTRL_CLOSED  0
`define PACDAC_CTRL_CLAMP   1
`define PACDAC_CODE_MID     12'h7ff
`define PACDAC_CODE_MAX     12'hfff
`define PACDAC_GAIN_RST     3'h0
`define PACDAC_GAIN_MAX     3'h7
`define PACDAC_SEQ_RST      12'h000
`define PACDAC_TEMP_MS      5
`define PACDAC_CLK_KHZ      25000
`define PACDAC_TEMP_CYC     (`PACDAC_TEMP_MS * `PACDAC_CLK_KHZ)
`endif

// File: pacdac_pkg.sv
// Types shared by the DAC update and monitor block.
package pacdac_pkg;
	typedef struct packed {
		logic       copy;
		logic       load;
		logic [11:0] code;
	} pacdac_code_t;
	typedef enum logic [2:0] {
		PACDAC_IDLE = 3'b001,
		PACDAC_CONV = 3'b010,
		PACDAC_STORE = 3'b100
	} pacdac_seq_t;
endpackage

// File: pacdac_chan.sv
// One DAC channel with input stage, output stage and deferred load.
`timescale 1ns/100ps
`include "pacdac_regs.svh"
module pacdac_chan
	import pacdac_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        wr,
	input  wire logic        load,
	input  wire logic [11:0] code,
	input  wire logic        strobe,
	output logic [11:0]      in_code,
	output logic [11:0]      out_code,
	output logic             pending
);
	logic [11:0] next_in_code;
	logic [11:0] next_out_code;
	logic        next_pending;

	always_comb begin
		next_in_code = in_code;
		next_out_code = out_code;
		next_pending = pending;
		if (wr) begin
			next_in_code = code; // R15
			next_pending = load; // R12
			if (!load)
				next_out_code = code; // R12
		end else if (strobe && pending) begin
			next_out_code = in_code; // R18
			next_pending = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			in_code <= 12'h000;
			out_code <= 12'h000;
			pending <= 1'b0;
		end else begin
			in_code <= next_in_code;
			out_code <= next_out_code;
			pending <= next_pending;
		end
	end
endmodule

// File: pacdac_top.sv
// DAC code registers, range selects and internal monitor sequencing.
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`include "pacdac_regs.svh"
module pacdac_top
	import pacdac_pkg::*;
(
	input  wire logic                     CLK_IN,
	input  wire logic                     SYS_RST_IN,
	input  wire logic [`PACDAC_ADDR_W-1:0] ADDR_IN,
	input  wire logic [15:0]              WDATA_IN,
	input  wire logic                     WR_IN,
	input  wire logic                     RD_IN,
	output logic [15:0]                   RDATA_OUT,
	input  wire logic                     DAC_LOAD_STROBE_IN,
	input  wire logic [11:0]              ADC_RESULT_IN,
	input  wire logic                     ADC_DONE_IN,
	output logic                          ADC_START_OUT,
	output logic [3:0]                    ADC_CHAN_OUT,
	output logic                          ADC_SINGLE_ENDED_OUT,
	output logic                          TEMP_START_OUT,
	output logic [2:0]                    SENSE_GAIN_OUT,
	output logic                          DAC_CLAMP_OUT,
	output logic [95:0]                   DAC_CODE_OUT,
	output logic [15:0]                   DAC_RANGE_OUT
);
	logic [1:0]  strobe_sync;
	logic [1:0]  done_sync;
	logic [11:0] res_sync [0:1];
	logic        strobe_seen;
	logic        next_strobe_seen;
	logic [11:0] in_code [0:7];
	logic [11:0] out_code [0:7];
	logic [7:0]  pending;
	logic [7:0]  chan_wr;
	logic        code_wr;
	logic [2:0]  wsel;
	pacdac_code_t wcode;
	logic [7:0]  range_bi;
	logic [7:0]  range_uni;
	logic [1:0]  ctrl;
	logic [2:0]  gain;
	logic [11:0] seq_en;
	logic [7:0]  next_range_bi;
	logic [7:0]  next_range_uni;
	logic [1:0]  next_ctrl;
	logic [2:0]  next_gain;
	logic [11:0] next_seq_en;
	logic [15:0] next_rdata;
	pacdac_seq_t state;
	pacdac_seq_t next_state;
	logic [3:0]  chan;
	logic [3:0]  next_chan;
	logic [11:0] result [0:11];
	logic [11:0] next_result [0:11];
	logic [22:0] temp_cnt;
	logic [22:0] next_temp_cnt;
	logic        next_temp_start;
	logic        next_adc_start;
	logic        done_rise;
	logic        done_prev;
	logic        in_page;
	logic        out_page;
	logic        res_page;
	logic [95:0] next_code_out;

	// Strobe, done and result pins cross two flops before use; the first stage feeds only the second.
	always_ff @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			strobe_sync <= 2'b00;
			done_sync <= 2'b00;
			res_sync[0] <= 12'h000;
			res_sync[1] <= 12'h000;
			done_prev <= 1'b0;
		end else begin
			strobe_sync <= {strobe_sync[0], DAC_LOAD_STROBE_IN};
			done_sync <= {done_sync[0], ADC_DONE_IN};
			res_sync[0] <= ADC_RESULT_IN;
			res_sync[1] <= res_sync[0];
			done_prev <= done_sync[1];
		end
	end
	assign done_rise = done_sync[1] && !done_prev;

	// Strobe is level sensitive, so a held strobe keeps loading later deferred writes.
	always_comb begin
		next_strobe_seen = strobe_sync[1];
	end
	always_ff @(posedge CLK_IN) begin
		if (SYS_RST_IN)
			strobe_seen <= 1'b0;
		else
			strobe_seen <= next_strobe_seen;
	end

	assign wcode = pacdac_code_t'({WDATA_IN[`PACDAC_CODE_COPY], WDATA_IN[`PACDAC_CODE_LOAD],
		WDATA_IN[11:0]});
	assign in_page = ADDR_IN[5:3] == 3'(`PACDAC_DAC_IN_BASE >> 3);
	assign out_page = ADDR_IN[5:3] == 3'(`PACDAC_DAC_OUT_BASE >> 3);
	assign res_page = ADDR_IN[5:4] == 2'(`PACDAC_RES_BASE >> 4) && ADDR_IN[3:0] < 4'hc;
	assign code_wr = WR_IN && in_page;
	assign wsel = ADDR_IN[2:0];

	// Channels 0 to 3 are bipolar, 4 to 7 unipolar.
	always_comb begin
		chan_wr = 8'h00;
		if (code_wr) begin
			chan_wr[wsel] = 1'b1;
			if (wcode.copy) begin
				if (wsel[2])
					chan_wr[7:4] = 4'hf; // R14
				else if (!ctrl[`PACDAC_CTRL_CLOSED])
					chan_wr[3:0] = 4'hf; // R13 R19
			end
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_chan
			pacdac_chan u_chan (
				.clk      (CLK_IN),
				.rst      (SYS_RST_IN),
				.wr       (chan_wr[gi]),
				.load     (wcode.load),
				.code     (wcode.code),
				.strobe   (strobe_seen),
				.in_code  (in_code[gi]),
				.out_code (out_code[gi]),
				.pending  (pending[gi])
			); // R09 R15
		end
	endgenerate

	// Register writes and read data, one cycle after the read strobe.
	always_comb begin
		next_range_bi = range_bi;
		next_range_uni = range_uni;
		next_ctrl = ctrl;
		next_gain = gain;
		next_seq_en = seq_en;
		next_rdata = 16'h0000;
		if (WR_IN) begin
			unique case (ADDR_IN)
				`PACDAC_RANGE_BI: next_range_bi = WDATA_IN[7:0]; // R10
				`PACDAC_RANGE_UNI: next_range_uni = WDATA_IN[7:0]; // R11
				`PACDAC_CTRL: next_ctrl = WDATA_IN[1:0];
				`PACDAC_GAIN: next_gain = WDATA_IN[2:0]; // R02
				`PACDAC_SEQ_EN: next_seq_en = WDATA_IN[11:0]; // R05
				default: ;
			endcase
		end
		if (RD_IN) begin
			if (in_page)
				next_rdata = {4'h0, in_code[ADDR_IN[2:0]]};
			else if (out_page)
				next_rdata = {3'h0, pending[ADDR_IN[2:0]], out_code[ADDR_IN[2:0]]};
			else if (res_page)
				next_rdata = {4'h0, result[ADDR_IN[3:0]]}; // R01 R04 R07 R08
			else begin
				unique case (ADDR_IN)
					`PACDAC_RANGE_BI: next_rdata = {8'h00, range_bi};
					`PACDAC_RANGE_UNI: next_rdata = {8'h00, range_uni};
					`PACDAC_CTRL: next_rdata = {14'h0000, ctrl};
					`PACDAC_GAIN: next_rdata = {13'h0000, gain};
					`PACDAC_SEQ_EN: next_rdata = {4'h0, seq_en};
					`PACDAC_STATUS: next_rdata = {5'h00, state, pending};
					default: next_rdata = 16'h0000;
				endcase
			end
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			range_bi <= 8'h00;
			range_uni <= 8'h00;
			ctrl <= 2'b00;
			gain <= `PACDAC_GAIN_RST;
			seq_en <= `PACDAC_SEQ_RST;
			RDATA_OUT <= 16'h0000;
		end else begin
			range_bi <= next_range_bi;
			range_uni <= next_range_uni;
			ctrl <= next_ctrl;
			gain <= next_gain;
			seq_en <= next_seq_en;
			RDATA_OUT <= next_rdata;
		end
	end

	// Sequencer walks enabled internal channels 0 to 11 in fixed order.
	always_comb begin
		next_state = state;
		next_chan = chan;
		next_adc_start = 1'b0;
		next_temp_start = 1'b0;
		next_temp_cnt = temp_cnt + 23'd1;
		for (int i = 0; i < 12; i++)
			next_result[i] = result[i];
		if (temp_cnt == 23'(`PACDAC_TEMP_CYC - 1)) begin
			next_temp_cnt = 23'd0;
			next_temp_start = 1'b1; // R03
		end
		unique case (state)
			PACDAC_IDLE: begin
				if (seq_en[chan]) begin
					next_adc_start = 1'b1; // R05
					next_state = PACDAC_CONV;
				end else
					next_chan = (chan == 4'd11) ? 4'd0 : chan + 4'd1;
			end
			PACDAC_CONV: begin
				if (done_rise)
					next_state = PACDAC_STORE;
			end
			PACDAC_STORE: begin
				next_result[chan] = res_sync[1];
				next_chan = (chan == 4'd11) ? 4'd0 : chan + 4'd1;
				next_state = PACDAC_IDLE;
			end
			default: next_state = PACDAC_IDLE;
		endcase
	end

	always_ff @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			state <= PACDAC_IDLE;
			chan <= 4'd0;
			temp_cnt <= 23'd0;
			ADC_START_OUT <= 1'b0;
			TEMP_START_OUT <= 1'b0;
			ADC_CHAN_OUT <= 4'd0;
			for (int i = 0; i < 12; i++)
				result[i] <= 12'h000;
		end else begin
			state <= next_state;
			chan <= next_chan;
			temp_cnt <= next_temp_cnt;
			ADC_START_OUT <= next_adc_start;
			TEMP_START_OUT <= next_temp_start;
			ADC_CHAN_OUT <= next_chan;
			for (int i = 0; i < 12; i++)
				result[i] <= next_result[i];
		end
	end

	always_comb begin
		next_code_out = 96'h0;
		for (int i = 0; i < 8; i++)
			next_code_out[i*12 +: 12] = out_code[i]; // R16
	end

	// Clamp is applied downstream, so the stored output codes survive it.
	always_ff @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			ADC_SINGLE_ENDED_OUT <= 1'b1;
			SENSE_GAIN_OUT <= `PACDAC_GAIN_RST;
			DAC_CLAMP_OUT <= 1'b0;
			DAC_CODE_OUT <= 96'h0;
			DAC_RANGE_OUT <= 16'h0000;
		end else begin
			ADC_SINGLE_ENDED_OUT <= 1'b1; // R06
			SENSE_GAIN_OUT <= next_gain;
			DAC_CLAMP_OUT <= next_ctrl[`PACDAC_CTRL_CLAMP]; // R17
			DAC_CODE_OUT <= next_code_out; // R16
			DAC_RANGE_OUT <= {next_range_uni, next_range_bi}; // R10 R11
		end
	end

	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (SYS_RST_IN);

	imm_load_a: assert property (code_wr && !wcode.load |=> // R12
		out_code[$past(wsel)] == $past(WDATA_IN[11:0])) else $error("Immediate write not applied.");
	defer_a: assert property (code_wr && wcode.load && !strobe_seen |=> // R12
		out_code[$past(wsel)] == $past(out_code[wsel]))
		else $error("Deferred write applied early.");
	strobe_xfer_a: assert property (strobe_seen && pending[0] && !chan_wr[0] |=> // R18
		out_code[0] == $past(in_code[0]) && !pending[0]) else $error("Strobe load missed.");
	uni_copy_a: assert property (code_wr && wcode.copy && wsel[2] && !wcode.load |=> // R14
		out_code[4] == out_code[7]) else $error("Unipolar copy failed.");
	bi_copy_a: assert property (code_wr && wcode.copy && !wsel[2] && !ctrl[0] && !wcode.load
		|=> out_code[0] == out_code[3]) else $error("Bipolar copy failed."); // R13
	closed_copy_a: assert property (code_wr && wcode.copy && !wsel[2] && ctrl[0] |-> // R19
		chan_wr[3:0] == 4'(4'h1 << wsel[1:0])) else $error("Closed loop copy broadcast.");
	single_end_a: assert property (##1 ADC_SINGLE_ENDED_OUT) else $error("Not single ended."); // R06
	store_a: assert property (state == PACDAC_STORE |=> // R05
		result[$past(chan)] == $past(res_sync[1])) else $error("Result not stored.");
	temp_a: assert property (TEMP_START_OUT == (temp_cnt == 23'd0 && // R03
		$past(temp_cnt) != 23'd0)) else $error("Temp pulse off count.");
	clamp_a: assert property ($rose(DAC_CLAMP_OUT) |-> // R17
		DAC_CODE_OUT[11:0] == $past(out_code[0])) else $error("Clamp changed code.");

	// The refresh interval outlasts any short run, so its counter is bounded instead.
	temp_bound_a: assert property (temp_cnt < 23'(`PACDAC_TEMP_CYC)) // R03
		else $error("Refresh count overrun.");
	start_pulse_a: assert property (ADC_START_OUT |=> // R05
		!ADC_START_OUT)
		else $error("Start pulse long.");
	start_chan_a: assert property (ADC_START_OUT |-> // R05
		state == PACDAC_CONV && ADC_CHAN_OUT == chan)
		else $error("Start channel wrong.");
	skip_chan_a: assert property (state == PACDAC_IDLE && !seq_en[chan] |=> // R05
		!ADC_START_OUT && state == PACDAC_IDLE)
		else $error("Disabled channel converted.");
	conv_wait_a: assert property (state == PACDAC_CONV && !done_rise |=> // R05
		state == PACDAC_CONV)
		else $error("Conversion left early.");
	seq_order_a: assert property (state == PACDAC_STORE |=> // R05
		chan == (($past(chan) == 4'd11) ? 4'd0 : $past(chan) + 4'd1))
		else $error("Sequence order broken.");
	load_hold_a: assert property (code_wr && wcode.load |=> // R12
		pending[$past(wsel)])
		else $error("Deferred write not pending.");
	imm_clear_a: assert property (code_wr && !wcode.load |=> // R12
		!pending[$past(wsel)])
		else $error("Immediate write left pending.");
	pend_hold_a: assert property (pending[4] && !strobe_seen && !chan_wr[4] |=> // R12
		pending[4] && out_code[4] == $past(out_code[4]))
		else $error("Pending code lost.");
	strobe_all_a: assert property (strobe_seen && pending[5] && !chan_wr[5] |=> // R18
		out_code[5] == $past(in_code[5]) && !pending[5])
		else $error("Unipolar strobe load missed.");
	uni_closed_a: assert property (code_wr && wcode.copy && wsel[2] |-> // R14
		chan_wr[7:4] == 4'hf)
		else $error("Unipolar copy not broadcast.");
	code_lag_a: assert property (1'b1 |=> // R16
		DAC_CODE_OUT[95:84] == $past(out_code[7]))
		else $error("Code output lags wrong.");
	out_read_a: assert property (RD_IN && out_page |=> // R15
		RDATA_OUT[11:0] == $past(out_code[ADDR_IN[2:0]]))
		else $error("Output stage read wrong.");
	res_read_a: assert property (RD_IN && res_page |=> // R01 R07
		RDATA_OUT[11:0] == $past(result[ADDR_IN[3:0]]))
		else $error("Result read wrong.");
	range_out_a: assert property (DAC_RANGE_OUT == {range_uni, range_bi}) // R10 R11
		else $error("Range output stale.");
	gain_out_a: assert property (SENSE_GAIN_OUT == gain) // R02
		else $error("Gain output stale.");
	clamp_out_a: assert property (DAC_CLAMP_OUT == ctrl[`PACDAC_CTRL_CLAMP]) // R17
		else $error("Clamp output stale.");

	cv_defer: cover property (code_wr && wcode.load ##[1:20] strobe_seen);
	cv_copy: cover property (code_wr && wcode.copy);
	cv_store: cover property (state == PACDAC_STORE);
	cv_closed: cover property (code_wr && wcode.copy && ctrl[`PACDAC_CTRL_CLOSED]);
	cv_strobe: cover property (strobe_seen && pending != 8'h00);
endmodule

// File: pacdac_adc_model.sv
// Converter model that answers the conversion requests of the monitor sequencer.
`timescale 1ns/100ps
module pacdac_adc_model (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       start_in,
	input  wire logic [3:0] chan_in,
	output logic [11:0]     result_out,
	output logic            done_out
);
	logic [3:0] cur_chan;
	initial begin
		done_out = 1'b0;
		result_out = 12'hfff;
		forever begin
			@(posedge clk_in);
			if (!rst_in && start_in) begin
				cur_chan = chan_in;
				// The old result is withdrawn so a stale value can never be stored.
				result_out <= ~result_out;
				// Odd channels answer slowly so the sequencer must wait on the handshake.
				repeat (cur_chan[0] ? 12 : 1) @(posedge clk_in);
				result_out <= {8'h5a, cur_chan};
				@(posedge clk_in);
				done_out <= 1'b1;
				repeat (2) @(posedge clk_in);
				done_out <= 1'b0;
			end
		end
	end
endmodule

// File: pacdac_top_tb_top.sv
// Self-checking bench for the DAC code registers and monitor sequencing.
`timescale 1ns/100ps
module pacdac_top_tb_top;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [5:0]  addr = 6'h00;
	logic [15:0] wdata = 16'h0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        ldstb = 1'b0;
	logic [15:0] rdata;
	logic [11:0] res;
	logic        done;
	logic        start;
	logic [3:0]  chan;
	logic        se;
	logic [2:0]  gain;
	logic        clamp;
	logic        temp;
	logic [95:0] codes;
	logic [15:0] ranges;
	logic [15:0] d;
	int          num_errors = 0;
	int          total_checks = 0;

	always #20 clk = ~clk;

	pacdac_top u_dut (
		.CLK_IN               (clk),
		.SYS_RST_IN           (rst),
		.ADDR_IN              (addr),
		.WDATA_IN             (wdata),
		.WR_IN                (wr),
		.RD_IN                (rd),
		.RDATA_OUT            (rdata),
		.DAC_LOAD_STROBE_IN   (ldstb),
		.ADC_RESULT_IN        (res),
		.ADC_DONE_IN          (done),
		.ADC_START_OUT        (start),
		.ADC_CHAN_OUT         (chan),
		.ADC_SINGLE_ENDED_OUT (se),
		.TEMP_START_OUT       (temp),
		.SENSE_GAIN_OUT       (gain),
		.DAC_CLAMP_OUT        (clamp),
		.DAC_CODE_OUT         (codes),
		.DAC_RANGE_OUT        (ranges)
	);

	pacdac_adc_model u_adc (
		.clk_in     (clk),
		.rst_in     (rst),
		.start_in   (start),
		.chan_in    (chan),
		.result_out (res),
		.done_out   (done)
	);

	task automatic complete_run();
		if (num_errors == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic timed_out(input string what);
		num_errors++;
		$display("CHECK FAILED %0t %s wait ran out", $time, what);
		complete_run();
	endtask

	task automatic bus_wr(input logic [5:0] a, input logic [15:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic bus_rd(input logic [5:0] a, output logic [15:0] v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask

	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask

	function automatic logic [15:0] oc(input int i);
		return {4'h0, codes[12*i+:12]};
	endfunction

	task automatic t_reset();
		for (int i = 0; i < 8; i++) chk(oc(i), 16'h0000, "reset code");
		chk({15'h0000, se}, 16'h0001, "single ended");
		chk({15'h0000, temp}, 16'h0000, "no early refresh");
	endtask

	task automatic t_immediate();
		logic [11:0] v;
		for (int i = 0; i < 8; i++) begin
			v = (i == 0) ? 12'hfff : 12'(12'h111 * i);
			bus_wr(6'(i), {4'h0, v});
			settle();
			chk(oc(i), {4'h0, v}, "direct code");
			bus_rd(6'h08 + 6'(i), d);
			chk(d, {4'h0, v}, "out stage read");
		end
	endtask

	task automatic t_deferred();
		int n;
		bus_wr(6'h01, 16'h13c5);
		bus_wr(6'h05, 16'h1a5a);
		settle();
		chk(oc(1), 16'h0111, "held bipolar");
		chk(oc(5), 16'h0555, "held unipolar");
		bus_rd(6'h09, d);
		chk(d, 16'h1111, "pending flag");
		@(posedge clk);
		ldstb <= 1'b1;
		for (n = 0; n < 10 && oc(1) === 16'h0111; n++) begin
			@(posedge clk);
			#1;
		end
		if (n == 10) timed_out("load strobe");
		chk(oc(1), 16'h03c5, "strobed bipolar");
		chk(oc(5), 16'h0a5a, "strobed together");
		@(posedge clk);
		ldstb <= 1'b0;
	endtask

	task automatic t_copy();
		bus_wr(6'h02, 16'h2abc);
		bus_wr(6'h06, 16'h2321);
		settle();
		for (int i = 0; i < 4; i++) chk(oc(i), 16'h0abc, "bipolar copy");
		for (int i = 4; i < 8; i++) chk(oc(i), 16'h0321, "unipolar copy");
		bus_wr(6'h12, 16'h0001);
		bus_wr(6'h03, 16'h2777);
		settle();
		chk(oc(3), 16'h0777, "closed loop addressed");
		for (int i = 0; i < 3; i++) chk(oc(i), 16'h0abc, "closed loop others");
		bus_wr(6'h12, 16'h0000);
	endtask

	task automatic t_clamp();
		bus_wr(6'h12, 16'h0002);
		settle();
		chk({15'h0000, clamp}, 16'h0001, "clamp on");
		chk(oc(0), 16'h0abc, "clamp keeps code");
		bus_wr(6'h12, 16'h0000);
		settle();
		chk({15'h0000, clamp}, 16'h0000, "clamp off");
		chk(oc(3), 16'h0777, "code after clamp");
	endtask

	task automatic t_config();
		for (int g = 0; g < 8; g++) begin
			bus_wr(6'h13, 16'(g));
			settle();
			chk({13'h0000, gain}, 16'(g), "gain select");
		end
		bus_wr(6'h10, 16'h0024);
		bus_wr(6'h11, 16'h0089);
		settle();
		chk(ranges, 16'h8924, "range selects");
		bus_rd(6'h11, d);
		chk(d, 16'h0089, "unipolar range read");
		bus_wr(6'h3f, 16'hffff);
		bus_rd(6'h3f, d);
		chk(d, 16'h0000, "unmapped read");
		chk(oc(0), 16'h0abc, "unmapped write");
	endtask

	task automatic t_seq();
		int n;
		bus_wr(6'h14, 16'h0003);
		d = 16'h0000;
		for (n = 0; n < 100 && d !== 16'h05a1; n++) bus_rd(6'h21, d);
		if (n == 100) timed_out("sequencer");
		bus_rd(6'h20, d);
		chk(d, 16'h05a0, "first result");
		chk({15'h0000, se}, 16'h0001, "internal single ended");
		bus_wr(6'h14, 16'h0000);
	endtask

	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		t_reset();
		t_immediate();
		t_deferred();
		t_copy();
		t_clamp();
		t_config();
		t_seq();
		complete_run();
	end
endmodule
